// *** hw/lhp_params.svh ***
`ifndef LHP_PARAMS_SVH
`define LHP_PARAMS_SVH

// Bus-mode strap codes (bus_mode_straps)
`define LHP_MODE_8080_8 2'h2
`define LHP_MODE_8080_4 2'h0
`define LHP_MODE_6800_8 2'h3
`define LHP_MODE_6800_4 2'h1
// Upper mode strap bits that must be zero in 4-bit modes
`define LHP_UPPER_4BIT 2'h0
// Bit positions of the straps
`define LHP_MODE_WIDTH_BIT 1
`define LHP_MODE_PROTO_BIT 0
// Strap counter value at which synchronised straps are taken
`define LHP_STRAP_WAIT 2'h2
// Reset values
`define LHP_BYTE_RST 8'h00
`define LHP_NIB_RST 4'h0
// Host strobe timing: minimum strobe width and setup, in ns
`define LHP_T_STROBE_NS 60
`define LHP_T_SETUP_NS 30
`define LHP_CLK_NS 10
`define LHP_STROBE_CYC ((`LHP_T_STROBE_NS + `LHP_CLK_NS - 1) / `LHP_CLK_NS)
`define LHP_SETUP_CYC ((`LHP_T_SETUP_NS + `LHP_CLK_NS - 1) / `LHP_CLK_NS)

`endif

// *** hw/lhp_pkg.sv ***
package lhp_pkg;
  typedef enum logic [1:0] {
    LHP_P8080_4 = 2'b00,
    LHP_P6800_4 = 2'b01,
    LHP_P8080_8 = 2'b10,
    LHP_P6800_8 = 2'b11
  } lhp_proto_t;

  typedef enum logic [2:0] {
    LHP_H_IDLE = 3'b000,
    LHP_H_SETUP = 3'b001,
    LHP_H_STROBE = 3'b010,
    LHP_H_HOLD = 3'b011,
    LHP_H_GAP = 3'b100
  } lhp_hstate_t;
endpackage

// *** hw/lhp_bus_if.sv ***
`timescale 1ns/1ps
// Parallel host bus; data lines are resolved from the two enables
interface lhp_bus_if;
  logic [1:0] chip_select_n;
  logic command_data_select;
  logic strobe_pin_zero;
  logic strobe_pin_one;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic [7:0] dev_data_o;
  logic dev_data_oe;
  logic [7:0] data;
  assign data = dev_data_oe ? dev_data_o :
                (host_data_oe ? host_data_o : 8'h00);

  modport device (
    input chip_select_n, command_data_select, strobe_pin_zero,
    input strobe_pin_one, data,
    output dev_data_o, dev_data_oe
  );
  modport host (
    output chip_select_n, command_data_select, strobe_pin_zero,
    output strobe_pin_one, host_data_o, host_data_oe,
    input data
  );
endinterface

// *** hw/lhp_device.sv ***
`timescale 1ns/1ps
`include "lhp_params.svh"
module lhp_device
  import lhp_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  lhp_bus_if.device BUS,
  input wire logic [1:0] BUS_MODE_STRAPS,
  input wire logic [1:0] UPPER_STRAPS,
  input wire logic [7:0] RD_BYTE,
  input wire logic RD_READY,
  output logic CMD_VALID,
  output logic [7:0] CMD_BYTE,
  output logic WR_VALID,
  output logic [7:0] WR_BYTE,
  input wire logic WR_READY,
  output logic RD_REQ,
  output logic STRAP_ERR
);
  // Two-flop synchronisers for every host bus pin
  logic [12:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
  logic [7:0] din;
  logic [1:0] csn;
  logic dsel, sp0, sp1;
  always_comb begin
    nxt_s1 = {BUS.chip_select_n, BUS.command_data_select,
              BUS.strobe_pin_zero, BUS.strobe_pin_one, BUS.data};
    nxt_s2 = s1_ff;
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s1_ff <= 13'h1F00;
      s2_ff <= 13'h1F00;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end
  assign {csn, dsel, sp0, sp1, din} = s2_ff;

  // Straps pass two flops, then are taken once after reset release
  logic [3:0] strap1_ff, strap2_ff, nxt_strap1, nxt_strap2;
  logic [1:0] strap_cnt_ff, nxt_strap_cnt;
  logic strap_take;
  lhp_proto_t proto_ff, nxt_proto;
  logic strap_err_ff, nxt_strap_err;
  always_comb begin
    nxt_strap1 = {UPPER_STRAPS, BUS_MODE_STRAPS};
    nxt_strap2 = strap1_ff;
    // Counter parks after the take, so later strap moves are ignored
    strap_take = (strap_cnt_ff == `LHP_STRAP_WAIT);
    nxt_strap_cnt = strap_cnt_ff;
    if (strap_cnt_ff != 2'h3) begin
      nxt_strap_cnt = strap_cnt_ff + 2'h1;
    end
    nxt_proto = strap_take ? lhp_proto_t'(strap2_ff[1:0]) : proto_ff;
    nxt_strap_err = strap_take ?
      (!strap2_ff[`LHP_MODE_WIDTH_BIT] &&
       strap2_ff[3:2] != `LHP_UPPER_4BIT) : strap_err_ff;
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      strap1_ff <= 4'h0;
      strap2_ff <= 4'h0;
      strap_cnt_ff <= 2'h0;
      proto_ff <= LHP_P8080_8;
      strap_err_ff <= 1'b0;
    end else begin
      strap1_ff <= nxt_strap1;
      strap2_ff <= nxt_strap2;
      strap_cnt_ff <= nxt_strap_cnt;
      proto_ff <= nxt_proto;
      strap_err_ff <= nxt_strap_err;
    end
  end
  logic wide, m6800;
  assign wide = proto_ff[`LHP_MODE_WIDTH_BIT];
  assign m6800 = proto_ff[`LHP_MODE_PROTO_BIT];

  // Decode strobes into read/write active levels
  logic sel, rd_act, wr_act;
  assign sel = (csn != 2'b11);
  always_comb begin
    if (m6800) begin
      rd_act = sp1 && sp0;
      wr_act = sp1 && !sp0;
    end else begin
      rd_act = !sp1;
      wr_act = !sp0;
    end
  end

  // Byte assembly, nibble phase, pipeline and bus drive
  logic rd_prev_ff, wr_prev_ff, nib_lo_ff, dsel_prev_ff;
  logic [1:0] csn_prev_ff;
  logic [3:0] hi_nib_ff;
  logic [7:0] pipe_ff, out_ff;
  logic oe_ff, rd_req_ff;
  logic nxt_rd_prev, nxt_wr_prev, nxt_nib_lo, nxt_dsel_prev, nxt_oe;
  logic nxt_rd_req;
  logic [1:0] nxt_csn_prev;
  logic [3:0] nxt_hi_nib;
  logic [7:0] nxt_pipe, nxt_out;
  logic wr_end, rd_end, rd_start, byte_done, push, push_dsel;
  logic [7:0] push_byte;
  logic buf_ready;
  always_comb begin
    nxt_rd_prev = sel && rd_act;
    nxt_wr_prev = sel && wr_act;
    nxt_csn_prev = csn;
    nxt_dsel_prev = dsel;
    wr_end = wr_prev_ff && !(sel && wr_act);
    rd_end = rd_prev_ff && !(sel && rd_act);
    rd_start = !rd_prev_ff && sel && rd_act;
    nxt_nib_lo = nib_lo_ff;
    nxt_hi_nib = hi_nib_ff;
    nxt_pipe = pipe_ff;
    nxt_out = out_ff;
    nxt_rd_req = 1'b0;
    push = 1'b0;
    push_dsel = dsel;
    push_byte = din;
    byte_done = 1'b0;
    if (!wide && (csn != csn_prev_ff || dsel != dsel_prev_ff)) begin
      nxt_nib_lo = 1'b0;
    end else if (wr_end || rd_end) begin
      if (wide) begin
        byte_done = 1'b1;
      end else if (!nib_lo_ff) begin
        nxt_nib_lo = 1'b1;
        nxt_hi_nib = din[3:0];
      end else begin
        nxt_nib_lo = 1'b0;
        byte_done = 1'b1;
        push_byte = {hi_nib_ff, din[3:0]};
      end
    end
    if (byte_done && wr_end) begin
      push = 1'b1;
    end
    // Read: present pipe byte, then advance pipe with fresh RAM byte
    if (rd_start) begin
      nxt_out = wide ? pipe_ff :
        (nib_lo_ff ? {4'h0, pipe_ff[3:0]} : {4'h0, pipe_ff[7:4]});
    end
    if (byte_done && rd_end && dsel) begin
      nxt_rd_req = 1'b1;
      nxt_pipe = RD_READY ? RD_BYTE : pipe_ff;
    end
    nxt_oe = sel && rd_act;
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
      nib_lo_ff <= 1'b0;
      dsel_prev_ff <= 1'b0;
      csn_prev_ff <= 2'h3;
      hi_nib_ff <= `LHP_NIB_RST;
      pipe_ff <= `LHP_BYTE_RST;
      out_ff <= `LHP_BYTE_RST;
      oe_ff <= 1'b0;
      rd_req_ff <= 1'b0;
    end else begin
      rd_prev_ff <= nxt_rd_prev;
      wr_prev_ff <= nxt_wr_prev;
      nib_lo_ff <= nxt_nib_lo;
      dsel_prev_ff <= nxt_dsel_prev;
      csn_prev_ff <= nxt_csn_prev;
      hi_nib_ff <= nxt_hi_nib;
      pipe_ff <= nxt_pipe;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      rd_req_ff <= nxt_rd_req;
    end
  end

  // Two-entry buffer so a stalled consumer loses no written byte until it and the output register are full
  logic [8:0] mem_ff [2];
  logic [8:0] nxt_mem [2];
  logic wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [1:0] cnt_ff, nxt_cnt;
  logic pop;
  logic cmd_v_ff, wr_v_ff, nxt_cmd_v, nxt_wr_v;
  logic [7:0] ob_ff, nxt_ob;
  assign buf_ready = (cnt_ff != 2'd2);
  always_comb begin
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    // Output register drains the buffer; commands take no ready, but wait behind a stalled write
    pop = (cnt_ff != 2'd0) && (!wr_v_ff || WR_READY) && !cmd_v_ff;
    nxt_cmd_v = 1'b0;
    nxt_wr_v = wr_v_ff && !WR_READY;
    nxt_ob = ob_ff;
    if (pop) begin
      nxt_rp = ~rp_ff;
      nxt_ob = mem_ff[rp_ff][7:0];
      nxt_cmd_v = !mem_ff[rp_ff][8];
      nxt_wr_v = mem_ff[rp_ff][8];
    end
    // Overflow only if host outruns buffer; byte then dropped
    if (push && buf_ready) begin
      nxt_mem[wp_ff] = {push_dsel, push_byte};
      nxt_wp = ~wp_ff;
    end
    nxt_cnt = cnt_ff + 2'((push && buf_ready) ? 1 : 0) - 2'(pop ? 1 : 0);
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mem_ff[0] <= 9'h000;
      mem_ff[1] <= 9'h000;
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'h0;
      cmd_v_ff <= 1'b0;
      wr_v_ff <= 1'b0;
      ob_ff <= `LHP_BYTE_RST;
    end else begin
      mem_ff <= nxt_mem;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
      cmd_v_ff <= nxt_cmd_v;
      wr_v_ff <= nxt_wr_v;
      ob_ff <= nxt_ob;
    end
  end

  assign BUS.dev_data_o = out_ff;
  assign BUS.dev_data_oe = oe_ff;
  assign CMD_VALID = cmd_v_ff;
  assign CMD_BYTE = ob_ff;
  assign WR_VALID = wr_v_ff;
  assign WR_BYTE = ob_ff;
  assign RD_REQ = rd_req_ff;
  assign STRAP_ERR = strap_err_ff;
endmodule

// *** hw/lhp_host.sv ***
`timescale 1ns/1ps
`include "lhp_params.svh"
module lhp_host
  import lhp_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  lhp_bus_if.host BUS,
  input wire logic [1:0] BUS_MODE_STRAPS,
  input wire logic REQ_VALID,
  input wire logic REQ_READ,
  input wire logic REQ_DSEL,
  input wire logic [7:0] REQ_BYTE,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_BYTE
);
  // Resynchronise the shared data lines before use
  logic [7:0] d1_ff, d2_ff;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      d1_ff <= 8'h00;
      d2_ff <= 8'h00;
    end else begin
      d1_ff <= BUS.data;
      d2_ff <= d1_ff;
    end
  end

  lhp_hstate_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic phase_ff, nxt_phase, rd_ff, nxt_rd, dsel_ff, nxt_dsel;
  logic [7:0] byte_ff, nxt_byte, rsp_ff, nxt_rsp;
  logic rsp_v_ff, nxt_rsp_v, strobe_ff, nxt_strobe, csn_ff, nxt_csn;
  logic wide, m6800;
  assign wide = BUS_MODE_STRAPS[`LHP_MODE_WIDTH_BIT];
  assign m6800 = BUS_MODE_STRAPS[`LHP_MODE_PROTO_BIT];
  // Strobe held long enough for device's 2-flop sync plus edge detect
  localparam logic [3:0] STROBE_CYC = 4'(`LHP_STROBE_CYC);
  localparam logic [3:0] SETUP_CYC = 4'(`LHP_SETUP_CYC);

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_phase = phase_ff;
    nxt_rd = rd_ff;
    nxt_dsel = dsel_ff;
    nxt_byte = byte_ff;
    nxt_rsp = rsp_ff;
    nxt_rsp_v = 1'b0;
    nxt_strobe = 1'b0;
    nxt_csn = csn_ff;
    case (st_ff)
      LHP_H_IDLE: begin
        if (REQ_VALID) begin
          nxt_rd = REQ_READ;
          nxt_dsel = REQ_DSEL;
          nxt_byte = REQ_BYTE;
          nxt_phase = 1'b0;
          nxt_csn = 1'b0;
          nxt_cnt = SETUP_CYC;
          nxt_st = LHP_H_SETUP;
        end
      end
      LHP_H_SETUP: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h0) begin
          nxt_strobe = 1'b1;
          nxt_cnt = STROBE_CYC;
          nxt_st = LHP_H_STROBE;
        end
      end
      LHP_H_STROBE: begin
        nxt_strobe = 1'b1;
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h0) begin
          // Sample read data just before the strobe ends
          if (rd_ff) begin
            if (wide) begin
              nxt_rsp = d2_ff;
            end else if (!phase_ff) begin
              nxt_rsp = {d2_ff[3:0], 4'h0};
            end else begin
              nxt_rsp = {rsp_ff[7:4], d2_ff[3:0]};
            end
          end
          nxt_strobe = 1'b0;
          nxt_cnt = SETUP_CYC;
          nxt_st = LHP_H_HOLD;
        end
      end
      LHP_H_HOLD: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h0) begin
          if (!wide && !phase_ff) begin
            nxt_phase = 1'b1;
            nxt_st = LHP_H_SETUP;
          end else begin
            nxt_rsp_v = rd_ff;
            nxt_st = LHP_H_GAP;
          end
        end
      end
      LHP_H_GAP: begin
        // Deselect between transfers so each one starts from a fresh select
        nxt_csn = 1'b1;
        nxt_st = LHP_H_IDLE;
      end
      default: begin
        nxt_st = LHP_H_IDLE;
      end
    endcase
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= LHP_H_IDLE;
      cnt_ff <= 4'h0;
      phase_ff <= 1'b0;
      rd_ff <= 1'b0;
      dsel_ff <= 1'b0;
      byte_ff <= 8'h00;
      rsp_ff <= 8'h00;
      rsp_v_ff <= 1'b0;
      strobe_ff <= 1'b0;
      csn_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      phase_ff <= nxt_phase;
      rd_ff <= nxt_rd;
      dsel_ff <= nxt_dsel;
      byte_ff <= nxt_byte;
      rsp_ff <= nxt_rsp;
      rsp_v_ff <= nxt_rsp_v;
      strobe_ff <= nxt_strobe;
      csn_ff <= nxt_csn;
    end
  end

  // Pin mapping per protocol; strobe_ff is the active phase
  assign BUS.chip_select_n = {1'b1, csn_ff};
  assign BUS.command_data_select = dsel_ff;
  assign BUS.strobe_pin_zero = m6800 ? rd_ff :
    !(strobe_ff && !rd_ff);
  assign BUS.strobe_pin_one = m6800 ? strobe_ff :
    !(strobe_ff && rd_ff);
  assign BUS.host_data_o = wide ? byte_ff :
    (phase_ff ? {4'h0, byte_ff[3:0]} : {4'h0, byte_ff[7:4]});
  assign BUS.host_data_oe = (st_ff != LHP_H_IDLE) && !rd_ff;
  assign REQ_READY = (st_ff == LHP_H_IDLE);
  assign RSP_VALID = rsp_v_ff;
  assign RSP_BYTE = rsp_ff;
endmodule

// *** verification/lhp_bus_assertions.sv ***
`timescale 1ns/1ps
// Watches the shared bus between host and device ends
module lhp_bus_assertions (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [1:0] BUS_MODE_STRAPS,
  input wire logic [1:0] chip_select_n,
  input wire logic command_data_select,
  input wire logic strobe_pin_zero,
  input wire logic strobe_pin_one,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  logic [1:0] live_ff;
  logic [1:0] nxt_live;
  logic sel;
  logic rd_act;
  logic wr_act;
  logic strb_act;

  // Skip the first two edges after reset while history fills
  always_comb begin
    nxt_live = {live_ff[0], 1'b1};
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      live_ff <= 2'h0;
    end else begin
      live_ff <= nxt_live;
    end
  end

  // Strobe decoding per protocol strap
  assign sel = !(&chip_select_n);
  assign rd_act = BUS_MODE_STRAPS[0] ? (strobe_pin_zero && strobe_pin_one)
                                     : !strobe_pin_one;
  assign wr_act = BUS_MODE_STRAPS[0] ? (!strobe_pin_zero && strobe_pin_one)
                                     : !strobe_pin_zero;
  assign strb_act = rd_act || wr_act;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence strobe_hold;
    strb_act [*6];
  endsequence
  sequence strobe_start;
    live_ff[1] && $rose(strb_act);
  endsequence
  // Device drive lags the wire by two sync flops and its output flop
  sequence rd_recent;
    rd_act || $past(rd_act) || $past(rd_act, 2) || $past(rd_act, 3);
  endsequence
  sequence strobe_again;
    strb_act && $past(strb_act);
  endsequence
  sequence sel_held;
    $stable(chip_select_n) && $stable(command_data_select);
  endsequence

  no_contention_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive data");
  dev_select_a: assert property (dev_data_oe |-> sel)
    else $error("device drives while deselected");
  dev_read_a: assert property (dev_data_oe |-> rd_recent)
    else $error("device drives outside read");
  host_read_a: assert property (live_ff[1] && rd_act |-> !host_data_oe)
    else $error("host drives during read");
  idle_strobe_a: assert property (live_ff[1] && !sel |-> !strb_act)
    else $error("strobe while deselected");
  write_data_a: assert property (live_ff[1] && wr_act |-> host_data_oe)
    else $error("write strobe without data");
  strobe_width_a: assert property (strobe_start |-> strobe_hold)
    else $error("strobe too short");
  select_setup_a: assert property (strobe_start |-> $past(sel, 3))
    else $error("strobe without select setup");
  select_steady_a: assert property (strobe_again |-> sel_held)
    else $error("select moved in strobe");
endmodule

// *** verification/lhp_parallel_host_port_tb.sv ***
`timescale 1ns/1ps
// Both ends joined on one bus; bench drives the user sides
module lcd_parallel_host_port_tb
  import lhp_pkg::*;
;
  localparam int DLY = 1;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [1:0] straps = 2'h2;
  logic [1:0] upper = 2'h0;
  logic [7:0] rd_byte = 8'h00;
  logic wr_ready = 1'b1;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic req_dsel = 1'b0;
  logic [7:0] req_byte = 8'h00;
  logic req_ready, rsp_valid, cmd_valid, wr_valid, strap_err, rd_req;
  logic [7:0] rsp_byte, cmd_byte, wr_byte, rsp;
  logic [7:0] cmd_q[$];
  logic [7:0] wr_q[$];
  logic zero_d = 1'b1;
  int wstrobes = 0;
  int rd_reqs = 0;
  int bad_count = 0;
  int tests_run = 0;
  logic [1:0] modes [4] = '{2'h2, 2'h0, 2'h3, 2'h1};

  always #5 CLK = ~CLK;

  lhp_bus_if bus_if ();
  lhp_device i_lhp_device (.CLK(CLK), .NRST(NRST), .BUS(bus_if),
    .BUS_MODE_STRAPS(straps), .UPPER_STRAPS(upper), .RD_BYTE(rd_byte),
    .RD_READY(1'b1), .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte),
    .WR_VALID(wr_valid), .WR_BYTE(wr_byte), .WR_READY(wr_ready),
    .RD_REQ(rd_req), .STRAP_ERR(strap_err));
  lhp_host i_lhp_host (.CLK(CLK), .NRST(NRST), .BUS(bus_if),
    .BUS_MODE_STRAPS(straps), .REQ_VALID(req_valid), .REQ_READ(req_read),
    .REQ_DSEL(req_dsel), .REQ_BYTE(req_byte), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_BYTE(rsp_byte));
  lhp_bus_assertions i_lhp_bus_assertions (.CLK(CLK), .NRST(NRST),
    .BUS_MODE_STRAPS(straps), .chip_select_n(bus_if.chip_select_n),
    .command_data_select(bus_if.command_data_select),
    .strobe_pin_zero(bus_if.strobe_pin_zero),
    .strobe_pin_one(bus_if.strobe_pin_one),
    .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));

  // Collect device outputs and count 8080 write strobes on the wire
  always @(posedge CLK) begin
    if (cmd_valid === 1'b1) cmd_q.push_back(cmd_byte);
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wr_q.push_back(wr_byte);
    if (rd_req === 1'b1) rd_reqs++;
    if (zero_d && !bus_if.strobe_pin_zero && !straps[0]) wstrobes++;
    zero_d <= bus_if.strobe_pin_zero;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Straps are only taken after reset, so each mode gets a fresh one
  task automatic do_reset(input logic [1:0] m, input logic [1:0] u);
    NRST = 1'b0;
    straps = m;
    upper = u;
    repeat (8) @(posedge CLK);
    #DLY NRST = 1'b1;
    repeat (3) @(posedge CLK);
    #DLY;
    cmd_q.delete();
    wr_q.delete();
    wstrobes = 0;
    rd_reqs = 0;
  endtask

  // One host transfer; request held until the edge that takes it
  task automatic host_req(input logic rd, input logic dsel,
                          input logic [7:0] b, output logic [7:0] r);
    int n;
    n = 0;
    r = 8'h00;
    while (req_ready !== 1'b1 && n < 300) begin
      @(posedge CLK);
      #DLY n++;
    end
    // A host that never comes back idle is a hang, counted as a mismatch
    if (n >= 300) begin
      bad_count++;
    end
    req_valid = 1'b1;
    req_read = rd;
    req_dsel = dsel;
    req_byte = b;
    @(posedge CLK);
    #DLY req_valid = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      if (rsp_valid === 1'b1) r = rsp_byte;
      @(posedge CLK);
      #DLY n++;
    end
    if (n >= 300) begin
      bad_count++;
    end
    if (rsp_valid === 1'b1) r = rsp_byte;
  endtask

  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    // Every protocol and width: command, data, dummy read, real read
    foreach (modes[i]) begin
      do_reset(modes[i], 2'h0);
      check({7'h00, strap_err}, 8'h00);
      rd_byte = 8'h96 ^ {6'h00, modes[i]};
      host_req(1'b0, 1'b0, 8'hC3 ^ {6'h00, modes[i]}, rsp);
      host_req(1'b0, 1'b1, 8'h5A ^ {6'h00, modes[i]}, rsp);
      host_req(1'b1, 1'b1, 8'h00, rsp);
      check(rsp, 8'h00);
      host_req(1'b1, 1'b1, 8'h00, rsp);
      check(rsp, rd_byte);
      repeat (20) @(posedge CLK);
      #DLY check(8'(cmd_q.size()), 8'h01);
      check(cmd_q[0], 8'hC3 ^ {6'h00, modes[i]});
      check(8'(wr_q.size()), 8'h01);
      check(wr_q[0], 8'h5A ^ {6'h00, modes[i]});
      check(8'(rd_reqs), 8'h02);
      if (!modes[i][0]) begin
        check(8'(wstrobes), modes[i][1] ? 8'h02 : 8'h04);
      end
    end
    // Stalled receiver: output stage and two entries kept, fourth dropped
    wr_ready = 1'b0;
    wr_q.delete();
    host_req(1'b0, 1'b1, 8'h11, rsp);
    host_req(1'b0, 1'b1, 8'h22, rsp);
    host_req(1'b0, 1'b1, 8'h33, rsp);
    host_req(1'b0, 1'b1, 8'h44, rsp);
    repeat (20) @(posedge CLK);
    #DLY wr_ready = 1'b1;
    repeat (10) @(posedge CLK);
    #DLY check(8'(wr_q.size()), 8'h03);
    check(wr_q[0], 8'h11);
    check(wr_q[1], 8'h22);
    check(wr_q[2], 8'h33);
    // Upper straps not cleared in a 4-bit mode
    do_reset(2'h1, 2'h1);
    check({7'h00, strap_err}, 8'h01);
    report_and_stop();
  end
endmodule
